// ---- return_and_rotate_left_exec.sv ----
`timescale 1ns/1ns
module return_and_rotate_left_exec
  import exec_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              opValid,
  input  wire logic [OPC_W-1:0]  opcode,
  input  wire logic [PC_W-1:0]   stack_top_entry,
  input  wire logic [DATA_W-1:0] fileRdData,
  input  wire logic              carryIn,
  output logic                   opReady,
  output logic                   stackPop,
  output logic                   pcLoad,
  output logic [PC_W-1:0]        pcValue,
  output logic                   wregWrite,
  output logic [DATA_W-1:0]      wregValue,
  output logic                   fileWrite,
  output logic [FADDR_W-1:0]     fileWrAddr,
  output logic [DATA_W-1:0]      fileWrData,
  output logic                   carryWrite,
  output logic                   carryValue,
  output logic                   opDone
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  dec_if dcd ();

  op_decoder i_op_decoder (
    .opcode (opcode),
    .dec    (dcd.dec)
  );

  // ---------------------------------------------------------------
  // rotate datapath
  // ---------------------------------------------------------------
  // the core presents the addressed register on fileRdData in the
  // accept cycle; no read port here, so a rotate needs no extra cycle
  logic [DATA_W-1:0] rotated;
  logic              rotCarry;

  always_comb begin
    rotated  = {fileRdData[DATA_W-2:0], carryIn};
    rotCarry = fileRdData[DATA_W-1];
  end

  // ---------------------------------------------------------------
  // acceptance
  // ---------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_SECOND} state_t;

  state_t   state_q, state_d;
  logic     ready_q, ready_d;
  logic     done_q,  done_d;
  op_kind_t takeKind;

  // one take decision feeds every group below, so they cannot
  // disagree about whether this cycle's opcode was accepted
  always_comb begin
    takeKind = OP_NONE;
    if (opValid && ready_q && state_q == ST_IDLE)
      takeKind = dcd.kind;
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // a return refuses only the next edge, so the take of a return and
  // that of its successor sit two edges apart
  always_comb begin
    state_d = state_q;
    ready_d = 1'b1;
    done_d  = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        unique case (takeKind)
          OP_RETLIT, OP_RETSUB: begin
            ready_d = 1'b0;
            state_d = ST_SECOND;
          end
          OP_ROTL: begin
            done_d = 1'b1;
          end
          OP_NONE: begin
            // other opcodes belong to other units
          end
        endcase
      end
      ST_SECOND: begin
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      done_q  <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // return: pop and program counter
  // ---------------------------------------------------------------
  logic            pop_q,  pop_d;
  logic            pcLd_q, pcLd_d;
  logic [PC_W-1:0] pc_q,   pc_d;

  // the entry is captured at accept, since the stack moves on the pop
  always_comb begin
    pop_d  = 1'b0;
    pcLd_d = 1'b0;
    pc_d   = pc_q;
    if (takeKind == OP_RETLIT || takeKind == OP_RETSUB) begin
      pop_d  = 1'b1;
      pcLd_d = 1'b1;
      pc_d   = stack_top_entry;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pop_q  <= 1'b0;
      pcLd_q <= 1'b0;
      pc_q   <= '0;
    end else begin
      pop_q  <= pop_d;
      pcLd_q <= pcLd_d;
      pc_q   <= pc_d;
    end
  end

  // ---------------------------------------------------------------
  // write-back: working register, file register, carry
  // ---------------------------------------------------------------
  logic               wW_q, wW_d;
  logic [DATA_W-1:0]  wV_q, wV_d;
  logic               fW_q, fW_d;
  logic [FADDR_W-1:0] fA_q, fA_d;
  logic [DATA_W-1:0]  fD_q, fD_d;
  logic               cW_q, cW_d;
  logic               cV_q, cV_d;

  // values hold between writes; only the strobes fall back to zero
  always_comb begin
    wW_d = 1'b0;
    wV_d = wV_q;
    fW_d = 1'b0;
    fA_d = fA_q;
    fD_d = fD_q;
    cW_d = 1'b0;
    cV_d = cV_q;
    unique case (takeKind)
      OP_RETLIT: begin
        wW_d = 1'b1;
        wV_d = dcd.literal;
      end
      OP_ROTL: begin
        cW_d = 1'b1;
        cV_d = rotCarry;
        if (dcd.toFile) begin
          fW_d = 1'b1;
          fA_d = dcd.fileAddr;
          fD_d = rotated;
        end else begin
          wW_d = 1'b1;
          wV_d = rotated;
        end
      end
      OP_RETSUB, OP_NONE: begin
        // no write-back; a plain return leaves every flag
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wW_q <= 1'b0;
      wV_q <= '0;
      fW_q <= 1'b0;
      fA_q <= '0;
      fD_q <= '0;
      cW_q <= 1'b0;
      cV_q <= 1'b0;
    end else begin
      wW_q <= wW_d;
      wV_q <= wV_d;
      fW_q <= fW_d;
      fA_q <= fA_d;
      fD_q <= fD_d;
      cW_q <= cW_d;
      cV_q <= cV_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // outputs come straight from flops; status bits other than carry
  // are never touched here
  always_comb begin
    opReady    = ready_q;
    stackPop   = pop_q;
    pcLoad     = pcLd_q;
    pcValue    = pc_q;
    wregWrite  = wW_q;
    wregValue  = wV_q;
    fileWrite  = fW_q;
    fileWrAddr = fA_q;
    fileWrData = fD_q;
    carryWrite = cW_q;
    carryValue = cV_q;
    opDone     = done_q;
  end

endmodule // return_and_rotate_left_exec

// ---- exec_pkg.sv ----
package exec_pkg;

  // ---------------------------------------------------------------
  // opcode layout
  // ---------------------------------------------------------------
  localparam int OPC_W    = 14;
  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 7;
  localparam int PC_W     = 13;
  localparam int DEST_BIT = 7;

  localparam logic [3:0]  RETLIT_TOP   = 4'hd;          // 11 01xx
  localparam logic [13:0] RETSUB_CODE  = 14'h0008;      // 00 0000 0000 1000
  localparam logic [5:0]  ROTL_TOP     = 6'h0d;         // 00 1101

  // ---------------------------------------------------------------
  // timing in instruction cycles
  // ---------------------------------------------------------------
  localparam int RET_CYCLES  = 2;
  localparam int ROTL_CYCLES = 1;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_RETLIT,
    OP_RETSUB,
    OP_ROTL
  } op_kind_t;

  // classify an opcode; used by the decoder only
  function automatic op_kind_t classify(input logic [OPC_W-1:0] opc);
    if (opc[13:10] == RETLIT_TOP)
      classify = OP_RETLIT;
    else if (opc == RETSUB_CODE)
      classify = OP_RETSUB;
    else if (opc[13:8] == ROTL_TOP)
      classify = OP_ROTL;
    else
      classify = OP_NONE;
  endfunction

endpackage

// ---- dec_if.sv ----
`timescale 1ns/1ns
// carries decoded fields from decoder to executor
interface dec_if;
  import exec_pkg::*;
  op_kind_t           kind;
  logic [DATA_W-1:0]  literal;
  logic               toFile;
  logic [FADDR_W-1:0] fileAddr;
  modport dec (output kind, output literal, output toFile, output fileAddr);
  modport exe (input kind, input literal, input toFile, input fileAddr);
endinterface

// ---- op_decoder.sv ----
`timescale 1ns/1ns
module op_decoder
  import exec_pkg::*;
(
  input  wire logic [OPC_W-1:0] opcode,
  dec_if.dec                    dec
);

  // ---------------------------------------------------------------
  // field split, purely combinational
  // ---------------------------------------------------------------
  always_comb begin
    dec.kind     = classify(opcode);
    dec.literal  = opcode[DATA_W-1:0];
    dec.toFile   = opcode[DEST_BIT];
    dec.fileAddr = opcode[FADDR_W-1:0];
  end

endmodule // op_decoder

// ---- exec_properties.sv ----
`timescale 1ns/1ns
module exec_properties
  import exec_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              opValid,
  input wire logic [OPC_W-1:0]  opcode,
  input wire logic [PC_W-1:0]   stack_top_entry,
  input wire logic [DATA_W-1:0] fileRdData,
  input wire logic              carryIn,
  input wire logic              opReady,
  input wire logic              stackPop,
  input wire logic              pcLoad,
  input wire logic [PC_W-1:0]   pcValue,
  input wire logic              wregWrite,
  input wire logic [DATA_W-1:0] wregValue,
  input wire logic              fileWrite,
  input wire logic [FADDR_W-1:0] fileWrAddr,
  input wire logic [DATA_W-1:0] fileWrData,
  input wire logic              carryWrite,
  input wire logic              carryValue,
  input wire logic              opDone
);
  // ---------------------------------------------------------------
  // accepted instruction kinds
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic isLit = opValid && opReady && opcode[13:10] == 4'hd;
  wire logic isRet = opValid && opReady && opcode == 14'h0008;
  wire logic isRot = opValid && opReady && opcode[13:8] == 6'h0d;

  // returns: pop in the first cycle, finish in the second
  property p_lit; isLit |=> wregWrite && wregValue == $past(opcode[7:0]);
  endproperty
  a_lit: assert property (p_lit) else $error("literal not loaded");
  property p_litpop; isLit |=> stackPop && pcLoad && !opReady
    && pcValue == $past(stack_top_entry) ##1 opDone && opReady; endproperty
  a_litpop: assert property (p_litpop) else $error("bad return");
  property p_ret; isRet |=> stackPop && !wregWrite && !carryWrite;
  endproperty
  a_ret: assert property (p_ret) else $error("bad plain return");
  property p_retpc; isRet |=> pcLoad && !opDone
    && pcValue == $past(stack_top_entry) ##1 opDone; endproperty
  a_retpc: assert property (p_retpc) else $error("bad return pc");
  // rotate: single cycle, carry is the only flag touched
  property p_rot; isRot |=> opDone && carryWrite && !stackPop && !pcLoad;
  endproperty
  a_rot: assert property (p_rot) else $error("bad rotate timing");
  property p_dest; isRot |=> fileWrite == $past(opcode[7])
    && wregWrite != $past(opcode[7])
    && (!fileWrite || fileWrAddr == $past(opcode[6:0])); endproperty
  a_dest: assert property (p_dest) else $error("bad rotate target");
  property p_bits; isRot |=> carryValue == $past(fileRdData[7])
    && (fileWrite ? fileWrData : wregValue)
       == {$past(fileRdData[6:0]), $past(carryIn)}; endproperty
  a_bits: assert property (p_bits) else $error("bad rotate result");
endmodule // exec_properties

bind return_and_rotate_left_exec exec_properties i_exec_properties (
  .sys_clk         (sys_clk),
  .rst_n           (rst_n),
  .opValid         (opValid),
  .opcode          (opcode),
  .stack_top_entry (stack_top_entry),
  .fileRdData      (fileRdData),
  .carryIn         (carryIn),
  .opReady         (opReady),
  .stackPop        (stackPop),
  .pcLoad          (pcLoad),
  .pcValue         (pcValue),
  .wregWrite       (wregWrite),
  .wregValue       (wregValue),
  .fileWrite       (fileWrite),
  .fileWrAddr      (fileWrAddr),
  .fileWrData      (fileWrData),
  .carryWrite      (carryWrite),
  .carryValue      (carryValue),
  .opDone          (opDone)
);

// ---- return_and_rotate_left_exec_tb.sv ----
`timescale 1ns/1ns
module return_and_rotate_left_exec_tb
  import exec_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, opValid = 0, carryIn = 0;
  logic [13:0] opcode = 0;
  logic [12:0] stack_top_entry = 0, pcValue;
  logic [7:0]  fileRdData = 0, wregValue, fileWrData;
  logic [6:0]  fileWrAddr;
  logic opReady, stackPop, pcLoad, wregWrite, fileWrite, carryWrite;
  logic carryValue, opDone;
  int   num_errors = 0, num_checks = 0;

  return_and_rotate_left_exec i_return_and_rotate_left_exec (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .opValid         (opValid),
    .opcode          (opcode),
    .stack_top_entry (stack_top_entry),
    .fileRdData      (fileRdData),
    .carryIn         (carryIn),
    .opReady         (opReady),
    .stackPop        (stackPop),
    .pcLoad          (pcLoad),
    .pcValue         (pcValue),
    .wregWrite       (wregWrite),
    .wregValue       (wregValue),
    .fileWrite       (fileWrite),
    .fileWrAddr      (fileWrAddr),
    .fileWrData      (fileWrData),
    .carryWrite      (carryWrite),
    .carryValue      (carryValue),
    .opDone          (opDone)
  );

  // 100 ns period
  initial forever #50 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(string n, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  // operand data goes with the opcode, since the file read is comb
  task put(logic [13:0] c, logic [12:0] t, logic [7:0] f, logic ci);
    @(posedge sys_clk);
    opValid <= 1;
    opcode <= c;
    stack_top_entry <= t;
    fileRdData <= f;
    carryIn <= ci;
  endtask

  task rotchk(logic [13:0] c, logic [7:0] f, logic ci);
    #1 chk("wregWrite", wregWrite, !c[7]);
    chk("fileWrite", fileWrite, c[7]);
    if (c[7]) chk("fileWrAddr", fileWrAddr, c[6:0]);
    chk("result", c[7] ? fileWrData : wregValue, {f[6:0], ci});
    chk("carry", {carryWrite, carryValue}, {1'b1, f[7]});
    chk("rotDone", {opDone, stackPop, pcLoad}, 3'b100);
  endtask

  // a rotate stays offered while the return holds off new opcodes
  task retrot(logic [13:0] c, logic [12:0] t, logic [13:0] r,
              logic [7:0] f, logic ci);
    put(c, t, 8'h00, 1'b0);
    put(r, 13'h0000, f, ci);
    #1 chk("pop", {stackPop, pcLoad, pcValue, opReady},
           {2'b11, t, 1'b0});
    chk("wregWrite", wregWrite, c[13]);
    if (c[13]) chk("wregValue", wregValue, c[7:0]);
    chk("flags", {carryWrite, opDone}, 2'b00);
    // the rotate is refused at this edge and taken at the next one
    @(posedge sys_clk);
    #1 chk("retDone", {opDone, opReady, carryWrite, stackPop}, 4'hc);
    chk("ready", {opReady, carryWrite}, 2'b10);
    @(posedge sys_clk) opValid <= 0;
    rotchk(r, f, ci);
  endtask

  // back-to-back rotates, both targets
  task rot_pair;
    put(14'h0d05, 13'h0000, 8'he6, 1'b0);
    put(14'h0dff, 13'h0000, 8'h33, 1'b1);
    rotchk(14'h0d05, 8'he6, 1'b0);
    @(posedge sys_clk) opValid <= 0;
    rotchk(14'h0dff, 8'h33, 1'b1);
  endtask

  // a reset in mid-run clears the outputs; ready returns one edge later
  task reset_mid;
    @(posedge sys_clk) rst_n <= 0;
    @(posedge sys_clk) rst_n <= 1;
    #1 chk("midReset", {opReady, opDone, wregWrite}, 3'b000);
    @(posedge sys_clk);
    #1 chk("midReady", opReady, 1'b1);
  endtask

  // a neighbouring return code is not ours and must do nothing
  task foreign_code;
    put(14'h0009, 13'h0123, 8'hff, 1'b1);
    @(posedge sys_clk) opValid <= 0;
    #1 chk("ignored", {stackPop, wregWrite, carryWrite, opDone},
           4'h0);
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    chk("resetReady", opReady, 1'b0);
    rst_n <= 1;
    repeat (3) @(posedge sys_clk);
    rot_pair;
    // don't-care bit 9 both ways (bit 8 always set), literal and address extremes
    retrot(14'h3500, 13'h0000, 14'h0d80, 8'h80, 1'b1);
    retrot(14'h37ff, 13'h1fff, 14'h0d7f, 8'h7f, 1'b0);
    retrot(14'h0008, 13'h0a55, 14'h0d00, 8'h01, 1'b1);
    reset_mid;
    foreign_code;
    give_verdict;
  end

  // runs take well under 200 cycles
  initial begin
    #200000;
    num_errors++;
    give_verdict;
  end
endmodule // return_and_rotate_left_exec_tb
